//--- rtl/encoder_position_init.sv
// Our own choices: the register addresses and the Wishbone interface to the registers.
`default_nettype none
module encoder_position_init #(
  parameter int unsigned VEL_CYCLES = encpos_pkg::VEL_CYCLES
) (
  input wire logic clk_i, // System clock, 100 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic cyc_i, // Wishbone cycle.
  input wire logic stb_i, // Wishbone strobe.
  input wire logic we_i, // Wishbone write enable.
  input wire logic [7:0] adr_i, // Wishbone byte address.
  input wire logic [3:0] sel_i, // Wishbone byte enables.
  input wire logic [31:0] dat_i, // Wishbone write data.
  output logic [31:0] dat_o, // Wishbone read data.
  output logic ack_o, // Wishbone acknowledge.
  input wire logic [31:0] enc_pos_i, // Serial encoder position, from link logic.
  input wire logic enc_ref_i, // Serial encoder referenced status.
  input wire logic enc_marker_i, // Serial encoder reference pulse.
  input wire logic enc_alarm_i, // Serial encoder internal alarm.
  input wire logic batt_low_i, // Backup power low.
  input wire logic batt_lost_i, // Backup power lost.
  input wire logic cfg_changed_i, // Scaling or positioning mode changed.
  input wire logic quad_a_i, // Quadrature channel A pin.
  input wire logic quad_b_i, // Quadrature channel B pin.
  input wire logic quad_z_i, // Quadrature marker pin.
  input wire logic home_switch_i, // Home switch pin, on at negative side.
  output logic pos_valid_o, // Position valid flag.
  output logic homing_o, // Home cycle in progress.
  output logic home_dir_neg_o, // Homing moves negative.
  output logic jog_grant_o, // Jog request accepted, one cycle.
  output logic [31:0] position_o // Reported axis position.
);
  localparam int unsigned VC_W = $clog2(VEL_CYCLES + 1);

  initial begin
    if (VEL_CYCLES < 2) begin
      $error("VEL_CYCLES must be at least 2");
    end
  end

  typedef enum logic [1:0] {S_IDLE, S_SW_NEG, S_SW_POS, S_MARK} home_state_type;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [encpos_pkg::CTRL_W-1:0] ctrl;
    logic [31:0] home_pos;
    logic [31:0] set_pos;
    logic [31:0] lim_lo;
    logic [31:0] lim_hi;
    logic [31:0] range_v;
    logic [31:0] offset;
    logic [31:0] quad_cnt;
    logic [31:0] vel_acc;
    logic [31:0] vel;
    logic [31:0] position;
    logic [15:0] err;
    logic valid;
    logic dir_neg;
    logic grant;
    home_state_type st;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    logic batt_low_prev;
    logic batt_lost_prev;
    logic [VC_W-1:0] vel_cnt;
  } regs_type;

  localparam regs_type RESET_STATE = '0;

  regs_type q;
  regs_type n;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic req;
  logic wr;
  logic [4:0] cmd;
  logic quad_mode;
  logic abs_mode;
  logic master_ok;
  logic marker;
  logic count_up;
  logic count_dn;
  logic both_chg;
  logic [31:0] raw;
  logic zero_in;
  logic [31:0] dflt;
  logic [31:0] rd;

  assign req = cyc_i && stb_i && !q.ack;
  assign wr = req && we_i;
  assign cmd = (wr && adr_i == encpos_pkg::OFF_CMD && sel_i[0]) ? dat_i[4:0] : 5'h00;
  assign quad_mode = q.ctrl[encpos_pkg::CTRL_QUAD];
  assign abs_mode = q.ctrl[encpos_pkg::CTRL_ABS] && !quad_mode;
  assign master_ok = !q.ctrl[encpos_pkg::CTRL_MASTER] || quad_mode;

  // Synchronised channels: bit 0 A, bit 1 B, bit 2 Z, bit 3 home switch.
  assign both_chg = (q.sync2[0] != q.prev[0]) && (q.sync2[1] != q.prev[1]);
  always_comb begin
    count_up = 1'b0;
    count_dn = 1'b0;
    // A leads B for the positive direction, so a phase swap turns the sign.
    case ({q.prev[1:0], q.sync2[1:0]})
      4'h1, 4'h7, 4'hE, 4'h8: count_up = 1'b1;
      4'h2, 4'hB, 4'hD, 4'h4: count_dn = 1'b1;
      default: begin
        count_up = 1'b0;
        count_dn = 1'b0;
      end
    endcase
  end

  assign marker = quad_mode ? (q.sync2[2] && !q.prev[2]) : enc_marker_i;

  // Default position used when restore fails.
  always_comb begin
    if (q.ctrl[encpos_pkg::CTRL_ROTARY]) begin
      zero_in = !q.lim_lo[31] && q.lim_lo == 32'h0000_0000 ||
                $signed(q.lim_lo) <= 0 && $signed(q.lim_lo + q.range_v) > 0;
      dflt = q.lim_lo + {q.range_v[31], q.range_v[31:1]};
    end else begin
      zero_in = $signed(q.lim_lo) <= 0 && $signed(q.lim_hi) >= 0;
      dflt = q.lim_lo + 32'((q.lim_hi - q.lim_lo) >> 1);
    end
    if (zero_in) begin
      dflt = 32'h0000_0000;
    end
  end

  always_comb begin
    case (adr_i)
      encpos_pkg::OFF_CTRL: rd = 32'(q.ctrl);
      encpos_pkg::OFF_HOME_POS: rd = q.home_pos;
      encpos_pkg::OFF_SET_POS: rd = q.set_pos;
      encpos_pkg::OFF_LIM_LO: rd = q.lim_lo;
      encpos_pkg::OFF_LIM_HI: rd = q.lim_hi;
      encpos_pkg::OFF_RANGE: rd = q.range_v;
      encpos_pkg::OFF_OFFSET: rd = q.offset;
      encpos_pkg::OFF_STATUS: begin
        rd = 32'h0000_0000;
        rd[encpos_pkg::STAT_VALID] = q.valid;
        rd[encpos_pkg::STAT_REF] = enc_ref_i;
        rd[encpos_pkg::STAT_HOMING] = q.st != S_IDLE;
        rd[encpos_pkg::STAT_DIR_NEG] = q.dir_neg;
        rd[encpos_pkg::STAT_MASTER_OK] = master_ok;
      end
      encpos_pkg::OFF_ERROR: rd = {16'h0000, q.err};
      encpos_pkg::OFF_POSITION: rd = q.position;
      encpos_pkg::OFF_VELOCITY: rd = q.vel;
      default: rd = 32'h0000_0000;
    endcase
  end

  always_comb begin
    n = q;
    n.ack = req;
    n.grant = 1'b0;
    if (req) begin
      n.rdata = rd;
    end
    if (wr) begin
      case (adr_i)
        encpos_pkg::OFF_CTRL: begin
          n.ctrl = encpos_pkg::CTRL_W'(merge(32'(q.ctrl), dat_i, sel_i));
        end
        encpos_pkg::OFF_HOME_POS: n.home_pos = merge(q.home_pos, dat_i, sel_i);
        encpos_pkg::OFF_SET_POS: n.set_pos = merge(q.set_pos, dat_i, sel_i);
        encpos_pkg::OFF_LIM_LO: n.lim_lo = merge(q.lim_lo, dat_i, sel_i);
        encpos_pkg::OFF_LIM_HI: n.lim_hi = merge(q.lim_hi, dat_i, sel_i);
        encpos_pkg::OFF_RANGE: n.range_v = merge(q.range_v, dat_i, sel_i);
        // The stored offset is kept by software across power loss and reloaded here.
        encpos_pkg::OFF_OFFSET: n.offset = merge(q.offset, dat_i, sel_i);
        encpos_pkg::OFF_ERROR: n.err = encpos_pkg::ERR_NONE;
        default: n.err = q.err;
      endcase
    end

    // Pin synchronisers; only the second stage is looked at.
    n.sync1 = {home_switch_i, quad_z_i, quad_b_i, quad_a_i};
    n.sync2 = q.sync1;
    n.prev = q.sync2;

    // Counter wraps naturally at the ends of its range.
    if (count_up && !both_chg) begin
      n.quad_cnt = q.quad_cnt + 32'h0000_0001;
    end else if (count_dn && !both_chg) begin
      n.quad_cnt = q.quad_cnt - 32'h0000_0001;
    end

    // Velocity in counts per window; sign comes from the phase order.
    if (q.vel_cnt == VC_W'(VEL_CYCLES - 1)) begin
      n.vel_cnt = '0;
      n.vel = q.vel_acc;
      n.vel_acc = 32'h0000_0000;
    end else begin
      n.vel_cnt = q.vel_cnt + VC_W'(1);
    end
    if (count_up && !both_chg) begin
      n.vel_acc = n.vel_acc + 32'h0000_0001;
    end else if (count_dn && !both_chg) begin
      n.vel_acc = n.vel_acc - 32'h0000_0001;
    end

    raw = quad_mode ? n.quad_cnt : enc_pos_i;

    // Lowest priority errors first so later ones overwrite them.
    n.batt_low_prev = batt_low_i;
    n.batt_lost_prev = batt_lost_i;
    if (q.ctrl[encpos_pkg::CTRL_BATT_EN] && abs_mode) begin
      if (batt_low_i && !q.batt_low_prev) begin
        n.err = encpos_pkg::ERR_BATT_LOW;
      end
      if (batt_lost_i && !q.batt_lost_prev) begin
        n.err = encpos_pkg::ERR_BATT_LOST;
      end
    end
    if (wr && adr_i == encpos_pkg::OFF_CTRL && !master_ok) begin
      n.err = q.err;
    end
    if (q.ctrl[encpos_pkg::CTRL_MASTER] && !quad_mode && q.err == encpos_pkg::ERR_NONE) begin
      n.err = encpos_pkg::ERR_MASTER_SRC;
    end

    if (cmd[encpos_pkg::CMD_JOG]) begin
      if (quad_mode && !q.valid) begin
        n.err = encpos_pkg::ERR_NOT_VALID;
      end else if (master_ok) begin
        n.grant = 1'b1;
      end
    end

    // Home cycle.
    case (q.st)
      S_IDLE: begin
        if (cmd[encpos_pkg::CMD_HOME]) begin
          n.valid = 1'b0;
          case (q.ctrl[encpos_pkg::CTRL_HMODE +: 2])
            encpos_pkg::HMODE_POS: begin
              n.st = S_MARK;
              n.dir_neg = 1'b0;
            end
            encpos_pkg::HMODE_NEG: begin
              n.st = S_MARK;
              n.dir_neg = 1'b1;
            end
            default: begin
              // The switch is on at the negative side of home.
              n.st = q.sync2[3] ? S_SW_POS : S_SW_NEG;
              n.dir_neg = !q.sync2[3];
            end
          endcase
        end
      end
      S_SW_NEG: begin
        if (q.sync2[3]) begin
          n.st = S_SW_POS;
          n.dir_neg = 1'b0;
        end
      end
      S_SW_POS: begin
        if (!q.sync2[3]) begin
          n.st = S_MARK;
        end
      end
      S_MARK: begin
        if (marker) begin
          n.st = S_IDLE;
          n.offset = q.home_pos - raw;
          n.valid = 1'b1;
        end
      end
      default: n.st = S_IDLE;
    endcase
    if (cmd[encpos_pkg::CMD_HALT] && q.st != S_IDLE) begin
      n.st = S_IDLE;
      n.valid = 1'b0;
    end

    // Set position; ignored while homing.
    if (cmd[encpos_pkg::CMD_SETPOS] && q.st == S_IDLE && !cmd[encpos_pkg::CMD_HOME]) begin
      if (abs_mode && !enc_ref_i) begin
        n.err = encpos_pkg::ERR_NOT_REF;
      end else begin
        n.offset = q.set_pos - raw;
        n.valid = 1'b1;
      end
    end

    // Power-up restore, run by software once configuration is loaded.
    if (cmd[encpos_pkg::CMD_RESTORE] && abs_mode && q.st == S_IDLE) begin
      if (enc_ref_i && !enc_alarm_i && !cfg_changed_i) begin
        n.valid = 1'b1;
      end else begin
        n.valid = 1'b0;
        n.offset = dflt - raw;
      end
    end

    n.position = raw + n.offset;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= RESET_STATE;
    end else begin
      q <= n;
    end
  end

  assign dat_o = q.rdata;
  assign ack_o = q.ack;
  assign pos_valid_o = q.valid;
  assign homing_o = q.st != S_IDLE;
  assign home_dir_neg_o = q.dir_neg;
  assign jog_grant_o = q.grant;
  assign position_o = q.position;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_home_clears_valid: assert property (
    (cmd[encpos_pkg::CMD_HOME] && q.st == S_IDLE) |=> !pos_valid_o && homing_o)
    else $error("home start did not clear valid");

  chk_halt_keeps_invalid: assert property (
    (cmd[encpos_pkg::CMD_HALT] && homing_o) |=> !pos_valid_o && !homing_o)
    else $error("halt left valid set or cycle running");

  chk_home_sets_position: assert property (
    (q.st == S_MARK && marker && !cmd[encpos_pkg::CMD_HALT])
    |=> pos_valid_o && position_o == $past(q.home_pos))
    else $error("home completion position wrong");

  chk_setpos_not_ref: assert property (
    (cmd[encpos_pkg::CMD_SETPOS] && q.st == S_IDLE && abs_mode && !enc_ref_i &&
     !cmd[encpos_pkg::CMD_HOME]) |=> q.err == encpos_pkg::ERR_NOT_REF && !$rose(pos_valid_o))
    else $error("unreferenced set position not rejected");

  chk_setpos_value: assert property (
    (cmd[encpos_pkg::CMD_SETPOS] && q.st == S_IDLE && !cmd[encpos_pkg::CMD_HOME] &&
     !cmd[encpos_pkg::CMD_RESTORE] && (!abs_mode || enc_ref_i))
    |=> pos_valid_o && position_o == $past(q.set_pos))
    else $error("set position value wrong");

  chk_both_edges_ignored: assert property (
    both_chg |=> q.quad_cnt == $past(q.quad_cnt))
    else $error("double transition changed count");

  chk_jog_refused: assert property (
    (cmd[encpos_pkg::CMD_JOG] && quad_mode && !pos_valid_o)
    |=> !jog_grant_o && q.err == encpos_pkg::ERR_NOT_VALID)
    else $error("jog granted without valid position");

  chk_batt_lost_code: assert property (
    (q.ctrl[encpos_pkg::CTRL_BATT_EN] && abs_mode && $rose(batt_lost_i) && cmd == 5'h00 &&
     master_ok) |=> q.err == encpos_pkg::ERR_BATT_LOST)
    else $error("lost backup power not reported");

  chk_reset_clears: assert property (
    $fell(rst_i) |-> !pos_valid_o && !homing_o)
    else $error("reset left valid or homing");

  chk_master_source: assert property (
    (q.ctrl[encpos_pkg::CTRL_MASTER] && !quad_mode && cmd[encpos_pkg::CMD_JOG])
    |=> !jog_grant_o)
    else $error("master axis accepted non-quadrature source");
endmodule
`default_nettype wire

//--- rtl/encpos_pkg.sv
`default_nettype none
package encpos_pkg;
  // Register byte offsets on the Wishbone slave.
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_HOME_POS = 8'h08;
  localparam logic [7:0] OFF_SET_POS = 8'h0C;
  localparam logic [7:0] OFF_LIM_LO = 8'h10;
  localparam logic [7:0] OFF_LIM_HI = 8'h14;
  localparam logic [7:0] OFF_RANGE = 8'h18;
  localparam logic [7:0] OFF_OFFSET = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_ERROR = 8'h24;
  localparam logic [7:0] OFF_POSITION = 8'h28;
  localparam logic [7:0] OFF_VELOCITY = 8'h2C;
  // Control register fields.
  localparam int unsigned CTRL_W = 7;
  localparam int unsigned CTRL_ABS = 0;
  localparam int unsigned CTRL_BATT_EN = 1;
  localparam int unsigned CTRL_MASTER = 2;
  localparam int unsigned CTRL_ROTARY = 3;
  localparam int unsigned CTRL_QUAD = 4;
  localparam int unsigned CTRL_HMODE = 5;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  // Command register bits, each a one-shot when written as one.
  localparam int unsigned CMD_HOME = 0;
  localparam int unsigned CMD_SETPOS = 1;
  localparam int unsigned CMD_HALT = 2;
  localparam int unsigned CMD_JOG = 3;
  localparam int unsigned CMD_RESTORE = 4;
  // Status register bits.
  localparam int unsigned STAT_VALID = 0;
  localparam int unsigned STAT_REF = 1;
  localparam int unsigned STAT_HOMING = 2;
  localparam int unsigned STAT_DIR_NEG = 3;
  localparam int unsigned STAT_MASTER_OK = 4;
  // Home modes.
  localparam logic [1:0] HMODE_POS = 2'h0;
  localparam logic [1:0] HMODE_NEG = 2'h1;
  // Error codes.
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_NOT_REF = 16'h0053;
  localparam logic [15:0] ERR_NOT_VALID = 16'h0054;
  localparam logic [15:0] ERR_MASTER_SRC = 16'h0055;
  localparam logic [15:0] ERR_BATT_LOW = 16'h00C1;
  localparam logic [15:0] ERR_BATT_LOST = 16'h00C2;
  // Velocity sampling window.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned VEL_WINDOW_NS = 1000000;
  localparam int unsigned VEL_CYCLES = VEL_WINDOW_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

//--- test/enc_shaft_model.sv
`default_nettype none
// One shaft feeds both the serial encoder and the quadrature pins, so marker and
// reference angle coincide.
module enc_shaft_model #(
  parameter int REV = 64
) (
  input wire logic clk_i, // System clock.
  input wire logic step_i, // One count step.
  input wire logic run_i, // Free-running steps.
  input wire logic dir_i, // High steps backwards.
  input wire logic swap_i, // A and B wires exchanged.
  input wire logic glitch_i, // Flip both phases at once.
  input wire logic lose_i, // Backup power lost.
  output logic a_o, // Phase A.
  output logic b_o, // Phase B.
  output logic z_o, // Marker level at one angle.
  output logic [31:0] pos_o, // Serial position.
  output logic ref_o, // Referenced status.
  output logic mark_o // Serial reference pulse.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cnt = 32'h0;
  logic [31:0] nxt;
  logic tog = 1'b0;
  logic inv = 1'b0;
  logic ref_q = 1'b0;
  logic mark_q = 1'b0;
  logic pa;
  logic pb;
  assign nxt = dir_i ? cnt - 32'h1 : cnt + 32'h1;
  assign pa = cnt[1] ^ cnt[0];
  assign pb = cnt[1];
  assign a_o = (swap_i ? pb : pa) ^ inv;
  assign b_o = (swap_i ? pa : pb) ^ inv;
  assign z_o = (cnt % REV) == 0;
  assign pos_o = cnt;
  assign ref_o = ref_q;
  assign mark_o = mark_q;
  always @(posedge clk_i) begin
    mark_q <= 1'b0;
    if (glitch_i) inv <= ~inv;
    if (run_i) tog <= ~tog;
    if (step_i || (run_i && tog)) begin
      cnt <= nxt;
      mark_q <= (nxt % REV) == 0;
    end
    if (lose_i) ref_q <= 1'b0;
    else if (mark_q) ref_q <= 1'b1;
  end
endmodule
`default_nettype wire

//--- test/encoder_position_init_bench.sv
`default_nettype none
module encoder_position_init_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, exp_v, hp, off, rs = 32'h8;
  logic step = 1'b0, run = 1'b0, dir = 1'b0, swap = 1'b0, glitch = 1'b0, lose = 1'b0;
  logic alarm = 1'b0, cfg = 1'b0, blow = 1'b0, blost = 1'b0, hsw = 1'b0;
  logic qa, qb, qz, eref, emark, ack_o, pos_valid_o, homing_o, home_dir_neg_o, jog_grant_o;
  logic [31:0] epos, dat_o, position_o;
  logic [31:0] tlo[3] = '{32'hFFFFFFF0, 32'h3E8, 32'h3E8};
  logic [31:0] thi[3] = '{32'h10, 32'hBB8, 32'hBB8};
  int err_total = 0, checked = 0, grants = 0, g0, n;

  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (jog_grant_o === 1'b1) grants <= grants + 1;

  encoder_position_init #(.VEL_CYCLES(8)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o),
    .ack_o(ack_o), .enc_pos_i(epos), .enc_ref_i(eref), .enc_marker_i(emark),
    .enc_alarm_i(alarm), .batt_low_i(blow), .batt_lost_i(blost), .cfg_changed_i(cfg),
    .quad_a_i(qa), .quad_b_i(qb), .quad_z_i(qz), .home_switch_i(hsw),
    .pos_valid_o(pos_valid_o), .homing_o(homing_o), .home_dir_neg_o(home_dir_neg_o),
    .jog_grant_o(jog_grant_o), .position_o(position_o));

  enc_shaft_model u_shaft (.clk_i(clk_i), .step_i(step), .run_i(run), .dir_i(dir),
    .swap_i(swap), .glitch_i(glitch), .lose_i(lose), .a_o(qa), .b_o(qb), .z_o(qz),
    .pos_o(epos), .ref_o(eref), .mark_o(emark));

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  // Restore fallback: zero when inside the limits, otherwise the middle of the travel.
  function automatic logic [31:0] dflt(logic [31:0] lo, logic [31:0] hi, logic rot);
    if ($signed(lo) <= 0 && $signed(hi) >= 0) return 32'h0;
    return rot ? lo + 32'h1F4 / 2 : lo + (hi - lo) / 2;
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_total++;
      end_sim();
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  task automatic cmd(input int b);
    wr(encpos_pkg::OFF_CMD, 32'h1 << b);
  endtask

  // Steps are spaced widely so nothing moves between marker capture and completion.
  task automatic mv(input int c, input logic d);
    repeat (c) begin
      step <= 1'b1;
      dir <= d;
      @(posedge clk_i);
      step <= 1'b0;
      tick(6);
    end
  endtask

  task automatic home_run();
    int k;
    k = 0;
    while (homing_o === 1'b1 && k < 200) begin
      mv(1, 1'b0);
      k++;
    end
    if (k >= 200) begin
      err_total++;
      end_sim();
    end
  endtask

  task automatic pulse_lose();
    lose <= 1'b1;
    @(posedge clk_i);
    lose <= 1'b0;
  endtask

  initial begin
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    chk(pos_valid_o, 1'b0);
    chk(homing_o, 1'b0);
    rd(encpos_pkg::OFF_STATUS, 32'h1 << encpos_pkg::STAT_MASTER_OK);
    wr(8'h30, rnd());
    rd(8'h30, 32'h0);
    $display("test reset done");

    wr(encpos_pkg::OFF_CTRL, 32'h10);
    n = rnd() % 20 + 1;
    mv(n, 1'b0);
    mv(2, 1'b1);
    exp_v = n - 2;
    rd(encpos_pkg::OFF_POSITION, exp_v);
    repeat (2) begin
      glitch <= 1'b1;
      @(posedge clk_i);
      glitch <= 1'b0;
      tick(6);
      rd(encpos_pkg::OFF_POSITION, exp_v);
    end
    wr(encpos_pkg::OFF_ERROR, 32'h0);
    g0 = grants;
    cmd(encpos_pkg::CMD_JOG);
    rd(encpos_pkg::OFF_ERROR, encpos_pkg::ERR_NOT_VALID);
    chk(grants, g0);
    wr(encpos_pkg::OFF_SET_POS, 32'hFFFFFFFE);
    cmd(encpos_pkg::CMD_SETPOS);
    chk(pos_valid_o, 1'b1);
    rd(encpos_pkg::OFF_POSITION, 32'hFFFFFFFE);
    mv(3, 1'b0);
    rd(encpos_pkg::OFF_POSITION, 32'h1);
    cmd(encpos_pkg::CMD_JOG);
    chk(grants, g0 + 1);
    hp = rnd();
    wr(encpos_pkg::OFF_HOME_POS, hp);
    cmd(encpos_pkg::CMD_HOME);
    chk(pos_valid_o, 1'b0);
    home_run();
    rd(encpos_pkg::OFF_POSITION, hp);
    chk(pos_valid_o, 1'b1);
    $display("test quadrature done");

    run <= 1'b1;
    tick(30);
    wb(1'b0, encpos_pkg::OFF_VELOCITY, 32'h0);
    chk({rdat[31], rdat == 32'h0}, 2'b00);
    swap <= 1'b1;
    tick(30);
    wb(1'b0, encpos_pkg::OFF_VELOCITY, 32'h0);
    chk({rdat[31], rdat == 32'h0}, 2'b10);
    run <= 1'b0;
    swap <= 1'b0;
    $display("test velocity done");

    pulse_lose();
    wr(encpos_pkg::OFF_CTRL, 32'h1);
    wr(encpos_pkg::OFF_ERROR, 32'h0);
    cmd(encpos_pkg::CMD_SETPOS);
    rd(encpos_pkg::OFF_ERROR, encpos_pkg::ERR_NOT_REF);
    wr(encpos_pkg::OFF_CTRL, 32'h0);
    wr(encpos_pkg::OFF_ERROR, 32'h0);
    cmd(encpos_pkg::CMD_SETPOS);
    rd(encpos_pkg::OFF_ERROR, 32'h0);
    rd(encpos_pkg::OFF_POSITION, 32'hFFFFFFFE);
    mv(64, 1'b0);
    wb(1'b0, encpos_pkg::OFF_STATUS, 32'h0);
    chk(rdat[1], 1'b1);
    for (int m = 0; m < 2; m++) begin
      wr(encpos_pkg::OFF_CTRL, {25'h0, 2'(m), 5'h1});
      cmd(encpos_pkg::CMD_HOME);
      chk(home_dir_neg_o, m);
      chk({homing_o, pos_valid_o}, 2'b10);
      cmd(encpos_pkg::CMD_HALT);
      mv(64, 1'b0);
      chk({homing_o, pos_valid_o}, 2'b00);
    end
    wr(encpos_pkg::OFF_CTRL, 32'h41);
    cmd(encpos_pkg::CMD_HOME);
    chk(home_dir_neg_o, 1'b1);
    hsw <= 1'b1;
    tick(6);
    chk(home_dir_neg_o, 1'b0);
    hsw <= 1'b0;
    tick(6);
    home_run();
    rd(encpos_pkg::OFF_POSITION, hp);
    $display("test homing done");

    wr(encpos_pkg::OFF_CTRL, 32'h3);
    wr(encpos_pkg::OFF_ERROR, 32'h0);
    blow <= 1'b1;
    tick(3);
    rd(encpos_pkg::OFF_ERROR, encpos_pkg::ERR_BATT_LOW);
    wr(encpos_pkg::OFF_ERROR, 32'h0);
    blost <= 1'b1;
    tick(3);
    rd(encpos_pkg::OFF_ERROR, encpos_pkg::ERR_BATT_LOST);
    blow <= 1'b0;
    blost <= 1'b0;
    wr(encpos_pkg::OFF_CTRL, 32'h1);
    wr(encpos_pkg::OFF_ERROR, 32'h0);
    blow <= 1'b1;
    tick(3);
    rd(encpos_pkg::OFF_ERROR, 32'h0);
    blow <= 1'b0;
    $display("test battery done");

    off = rnd();
    wr(encpos_pkg::OFF_OFFSET, off);
    cmd(encpos_pkg::CMD_RESTORE);
    chk(pos_valid_o, 1'b1);
    rd(encpos_pkg::OFF_POSITION, epos + off);
    for (int k = 0; k < 3; k++) begin
      wr(encpos_pkg::OFF_LIM_LO, tlo[k]);
      wr(encpos_pkg::OFF_LIM_HI, thi[k]);
      wr(encpos_pkg::OFF_RANGE, 32'h1F4);
      wr(encpos_pkg::OFF_CTRL, k == 2 ? 32'h9 : 32'h1);
      alarm <= k == 0;
      cfg <= k == 1;
      if (k == 2) pulse_lose();
      cmd(encpos_pkg::CMD_RESTORE);
      chk(pos_valid_o, 1'b0);
      rd(encpos_pkg::OFF_POSITION, dflt(tlo[k], thi[k], k == 2));
      alarm <= 1'b0;
      cfg <= 1'b0;
    end
    $display("test restore done");

    wr(encpos_pkg::OFF_ERROR, 32'h0);
    wr(encpos_pkg::OFF_CTRL, 32'h4);
    rd(encpos_pkg::OFF_ERROR, encpos_pkg::ERR_MASTER_SRC);
    wb(1'b0, encpos_pkg::OFF_STATUS, 32'h0);
    chk(rdat[4], 1'b0);
    wr(encpos_pkg::OFF_CTRL, 32'h14);
    wb(1'b0, encpos_pkg::OFF_STATUS, 32'h0);
    chk(rdat[4], 1'b1);
    $display("test master done");
    end_sim();
  end
endmodule
`default_nettype wire
